// File: src/adc_mode_channel_sequencer.sv
// mode and channel sequencer of a multichannel converter behind a serial command link
// Behaviour
// - command 8300h enters power-down at the chip-select rise ending that frame
// - power-down disables all analog circuitry including reference and buffer
// - with internal reference, results invalid for 15 ms after power-down exit
// - hardware power-down restores defaults; software power-down keeps register contents
// - power-down persists while no conversion command arrives and input stays low
// - register writes work in 16-clock frames; frames under 16 clocks give invalid output
// - register reads during power-down behave as in every other mode
// - a register write command leaves power-down in place; a conversion command exits it at the following chip-select rise
// - A000h starts auto scan; first channel valid only after a 32-clock command frame
// - scanned channel set comes from sequencing registers 01h and 02h
// - auto scan steps selected channels upward, one per frame, wrapping to lowest
// - each converted channel except the auxiliary input uses its own programmed input range
// - auto scan persists while no other command arrives and input stays low
// - repeating the auto command restarts the scan at the lowest channel
// - unselected channels may be powered down during auto scan
// - manual command picks one channel; accurate only after a 32-clock frame
// - manual channel is sampled at the chip-select fall opening the next frame
// - manual mode keeps sampling the same channel until another command
// - a channel chosen in one frame is sampled in the following frame
// - a conversion command's channel takes effect at the next chip-select fall; the mode changes at the chip-select rise
// - register reset accepted anytime; default power-up state from the next frame
// - manual codes: C000h channel 0, steps of 0400h, E000h auxiliary input
// - an all-zero command frame keeps the last mode and settings
// - frame opens at chip-select fall; command latched on 16th falling edge
// - command 8500h returns every program register to its default
`timescale 1ns/1ps
`default_nettype none

module adc_mode_channel_sequencer #(
    parameter int unsigned NUM_CH = 8,
    parameter int unsigned WAKE_CYCLES = adc_seq_pkg::WAKE_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic serialClk,
    input wire logic chipSelectN,
    input wire logic serialIn,
    input wire logic referenceSelect,
    input wire logic hwPowerDownN,
    output logic serialOut,
    output logic serialOutEn,
    output var adc_seq_pkg::seqMode_t mode,
    output var adc_seq_pkg::sampleInfo_t sample,
    output logic sampleStrobe,
    output logic analogEnable,
    output logic [NUM_CH-1:0] channelPowerEn
);
    localparam int CH_W = $clog2(NUM_CH);
    localparam int WAKE_W = $clog2(WAKE_CYCLES + 1);
    localparam logic [WAKE_W-1:0] WAKE_LOAD = WAKE_W'(WAKE_CYCLES);

    // program registers, sys_clk domain
    logic [7:0] seqSel_q;
    logic [7:0] seqPwr_q;
    logic [7:0] range_q [NUM_CH];

    function automatic logic [7:0] readReg(input logic [6:0] addr);
        logic [7:0] r;
        r = 8'h00;
        if (addr == adc_seq_pkg::ADDR_SEQ_SEL) begin
            r = seqSel_q;
        end else if (addr == adc_seq_pkg::ADDR_SEQ_PWR) begin
            r = seqPwr_q;
        end else if (addr >= adc_seq_pkg::ADDR_RANGE_BASE &&
                     addr < adc_seq_pkg::ADDR_RANGE_BASE + 7'(NUM_CH)) begin
            r = range_q[CH_W'(addr - adc_seq_pkg::ADDR_RANGE_BASE)];
        end
        return r;
    endfunction

    // ---------------- link domain ----------------
    logic [5:0] bitCnt_q;
    logic [15:0] shiftIn_q;
    logic [15:0] linkWord_q;
    logic wordTgl_q;
    logic fullTgl_q;
    logic [7:0] sdoShift_q;
    logic [15:0] wordIn;

    assign wordIn = {shiftIn_q[14:0], serialIn};

    // chip select high ends the frame, so the counter never relies on a late clock edge
    always_ff @(negedge serialClk or posedge chipSelectN) begin
        if (chipSelectN) begin
            bitCnt_q <= 6'h00;
            shiftIn_q <= 16'h0000;
        end else begin
            if (bitCnt_q != adc_seq_pkg::FULL_FRAME) begin
                bitCnt_q <= bitCnt_q + 6'h01;
            end
            shiftIn_q <= wordIn;
        end
    end

    always_ff @(negedge serialClk or negedge rst_n) begin
        if (!rst_n) begin
            linkWord_q <= 16'h0000;
            wordTgl_q <= 1'b0;
            fullTgl_q <= 1'b0;
        end else begin
            if (bitCnt_q == adc_seq_pkg::CMD_BITS - 6'h01) begin
                linkWord_q <= wordIn;
                wordTgl_q <= ~wordTgl_q;
            end
            if (bitCnt_q == adc_seq_pkg::FULL_FRAME - 6'h01) begin
                fullTgl_q <= ~fullTgl_q;
            end
        end
    end

    // register writes land after the 16th fall of their own frame, not at this point, so sampling them here is safe
    always_ff @(negedge serialClk or posedge chipSelectN) begin
        if (chipSelectN) begin
            sdoShift_q <= 8'h00;
        end else if (bitCnt_q == adc_seq_pkg::CMD_BITS - 6'h01) begin
            sdoShift_q <= wordIn[adc_seq_pkg::CMD_RW_BIT] ? 8'h00 :
                          readReg(wordIn[15:adc_seq_pkg::ADDR_LSB]);
        end else begin
            sdoShift_q <= {sdoShift_q[6:0], 1'b0};
        end
    end

    assign serialOut = sdoShift_q[7];
    assign serialOutEn = ~chipSelectN;

    // ---------------- sys_clk domain ----------------
    logic [4:0] syncMeta_q;
    logic [4:0] syncOut_q;
    logic [2:0] syncPrev_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            syncMeta_q <= adc_seq_pkg::SYNC_RST;
            syncOut_q <= adc_seq_pkg::SYNC_RST;
            syncPrev_q <= 3'h1;
        end else begin
            syncMeta_q <= {hwPowerDownN, referenceSelect, fullTgl_q, wordTgl_q, chipSelectN};
            syncOut_q <= syncMeta_q;
            syncPrev_q <= syncOut_q[2:0];
        end
    end

    logic csRise;
    logic csFall;
    logic wordEv;
    logic fullEv;
    logic refInternal;
    logic hwPd;

    assign csRise = syncOut_q[0] & ~syncPrev_q[0];
    assign csFall = ~syncOut_q[0] & syncPrev_q[0];
    assign wordEv = syncOut_q[1] ^ syncPrev_q[1];
    assign fullEv = syncOut_q[2] ^ syncPrev_q[2];
    assign refInternal = ~syncOut_q[3];
    assign hwPd = ~syncOut_q[4];

    // command captured in the current frame, acted on at its chip-select rise
    logic [15:0] pendCmd_q;
    logic pendValid_q;
    logic fullSeen_q;
    logic haveCmd;
    logic [15:0] cmdNow;
    logic frameFull;

    assign haveCmd = pendValid_q | wordEv;
    assign cmdNow = wordEv ? linkWord_q : pendCmd_q;
    assign frameFull = fullSeen_q | fullEv;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pendCmd_q <= 16'h0000;
            pendValid_q <= 1'b0;
            fullSeen_q <= 1'b0;
        end else if (csRise) begin
            pendValid_q <= 1'b0;
            fullSeen_q <= 1'b0;
        end else begin
            if (wordEv) begin
                pendCmd_q <= linkWord_q;
                pendValid_q <= 1'b1;
            end
            if (fullEv) begin
                fullSeen_q <= 1'b1;
            end
        end
    end

    logic isManual;
    logic isAux;
    logic isAuto;
    logic isConv;
    logic execNow;

    assign isManual = cmdNow[15:adc_seq_pkg::CMD_PREFIX_LSB] == adc_seq_pkg::CMD_MAN_PREFIX &&
                      cmdNow[9:0] == adc_seq_pkg::CMD_MAN_TAIL;
    assign isAux = cmdNow == adc_seq_pkg::CMD_AUXILIARY_INPUT_SELECT;
    assign isAuto = cmdNow == adc_seq_pkg::CMD_AUTO;
    assign isConv = isManual | isAux | isAuto;
    assign execNow = csRise & haveCmd;

    logic regReset;
    assign regReset = hwPd | (execNow && cmdNow == adc_seq_pkg::CMD_REGRESET);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            seqSel_q <= adc_seq_pkg::SEQ_SEL_RST;
            seqPwr_q <= adc_seq_pkg::SEQ_PWR_RST;
            for (int i = 0; i < NUM_CH; i++) begin
                range_q[i] <= adc_seq_pkg::RANGE_RST;
            end
        end else if (regReset) begin
            // software power-down never reaches here, so its settings survive
            seqSel_q <= adc_seq_pkg::SEQ_SEL_RST;
            seqPwr_q <= adc_seq_pkg::SEQ_PWR_RST;
            for (int i = 0; i < NUM_CH; i++) begin
                range_q[i] <= adc_seq_pkg::RANGE_RST;
            end
        end else if (wordEv && linkWord_q[adc_seq_pkg::CMD_RW_BIT]) begin
            if (linkWord_q[15:9] == adc_seq_pkg::ADDR_SEQ_SEL) begin
                seqSel_q <= linkWord_q[7:0];
            end else if (linkWord_q[15:9] == adc_seq_pkg::ADDR_SEQ_PWR) begin
                seqPwr_q <= linkWord_q[7:0];
            end
            for (int i = 0; i < NUM_CH; i++) begin
                if (linkWord_q[15:9] == adc_seq_pkg::ADDR_RANGE_BASE + 7'(i)) begin
                    range_q[i] <= linkWord_q[7:0];
                end
            end
        end
    end

    // mode transitions
    adc_seq_pkg::seqMode_t mode_q;
    adc_seq_pkg::seqMode_t modeD;

    always_comb begin
        modeD = mode_q;
        if (hwPd) begin
            modeD = adc_seq_pkg::MODE_PWRDN;
        end else if (csRise && !haveCmd) begin
            modeD = adc_seq_pkg::MODE_INVALID;
        end else if (execNow) begin
            if (cmdNow == adc_seq_pkg::CMD_PWRDN) begin
                modeD = adc_seq_pkg::MODE_PWRDN;
            end else if (cmdNow == adc_seq_pkg::CMD_REGRESET) begin
                modeD = adc_seq_pkg::MODE_IDLE;
            end else if (isAuto) begin
                modeD = adc_seq_pkg::MODE_AUTO;
            end else if (isManual || isAux) begin
                modeD = adc_seq_pkg::MODE_MANUAL;
            end
            // hold word and register access leave the mode alone
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= adc_seq_pkg::MODE_IDLE;
        end else begin
            mode_q <= modeD;
        end
    end

    assign mode = mode_q;

    // power gating follows the next mode so it switches at the frame end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            analogEnable <= 1'b1;
            channelPowerEn <= '1;
        end else begin
            analogEnable <= modeD != adc_seq_pkg::MODE_PWRDN;
            channelPowerEn <= {NUM_CH{modeD != adc_seq_pkg::MODE_PWRDN}} &
                              ~((modeD == adc_seq_pkg::MODE_AUTO) ?
                                seqPwr_q[NUM_CH-1:0] : '0);
        end
    end

    logic [WAKE_W-1:0] wakeCnt_q;
    logic pdExit;
    assign pdExit = mode_q == adc_seq_pkg::MODE_PWRDN && modeD != adc_seq_pkg::MODE_PWRDN;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wakeCnt_q <= '0;
        end else if (pdExit && refInternal) begin
            wakeCnt_q <= WAKE_LOAD;
        end else if (wakeCnt_q != '0) begin
            wakeCnt_q <= wakeCnt_q - WAKE_W'(1);
        end
    end

    // selection captured at the command frame end, applied at the next frame start
    localparam int CMD_CH_MSB = adc_seq_pkg::CMD_CH_LSB + 2;
    logic [3:0] manChan_q;
    logic restartScan_q;
    logic cmdShort_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            manChan_q <= 4'h0;
            restartScan_q <= 1'b0;
            cmdShort_q <= 1'b0;
        end else if (execNow && isConv) begin
            manChan_q <= isAux ? adc_seq_pkg::AUX_CHANNEL :
                         {1'b0, cmdNow[CMD_CH_MSB:adc_seq_pkg::CMD_CH_LSB]};
            restartScan_q <= isAuto;
            cmdShort_q <= !frameFull;
        end else if (csFall) begin
            restartScan_q <= 1'b0;
            cmdShort_q <= 1'b0;
        end
    end

    logic [NUM_CH-1:0] scanSet;
    assign scanSet = seqSel_q[NUM_CH-1:0] & ~seqPwr_q[NUM_CH-1:0];

    // lowest selected channel above 'after', or the lowest one when wrap is set
    function automatic logic [4:0] pickChan(input logic [NUM_CH-1:0] set,
                                            input logic [3:0] after, input logic wrap);
        logic [4:0] r;
        r = 5'h00;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (set[i] && (wrap || i > int'(after))) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction

    logic [4:0] nextUp;
    logic [4:0] lowest;
    logic [3:0] autoChan;
    assign nextUp = pickChan(scanSet, sample.channel, 1'b0);
    assign lowest = pickChan(scanSet, 4'h0, 1'b1);
    // an empty set parks on channel 0 instead of drifting
    assign autoChan = (restartScan_q || !nextUp[4]) ? (lowest[4] ? lowest[3:0] : 4'h0)
                                                    : nextUp[3:0];

    logic [3:0] frameChan;
    logic converting;
    assign frameChan = (mode_q == adc_seq_pkg::MODE_AUTO) ? autoChan : manChan_q;
    assign converting = mode_q == adc_seq_pkg::MODE_AUTO || mode_q == adc_seq_pkg::MODE_MANUAL;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sample <= '0;
            sampleStrobe <= 1'b0;
        end else begin
            sampleStrobe <= csFall && converting;
            if (csFall && converting) begin
                sample.channel <= frameChan;
                sample.range <= (frameChan[3] ? adc_seq_pkg::RANGE_RST :
                                 range_q[frameChan[CH_W-1:0]]);
                sample.valid <= wakeCnt_q == '0 && !cmdShort_q;
            end else if (!converting) begin
                sample.valid <= 1'b0;
            end
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence pdLeaveInternal;
        pdExit && refInternal && !hwPd;
    endsequence

    sequence autoRestartFrame;
        restartScan_q && csFall && mode_q == adc_seq_pkg::MODE_AUTO;
    endsequence

    pd_entry_a: assert property (execNow && !hwPd && cmdNow == adc_seq_pkg::CMD_PWRDN
        |=> mode_q == adc_seq_pkg::MODE_PWRDN ##1 !analogEnable)
        else $error("power-down command not obeyed");

    pd_circuit_a: assert property (mode_q == adc_seq_pkg::MODE_PWRDN
        |-> !analogEnable && channelPowerEn == '0)
        else $error("analog circuitry powered during power-down");

    wake_load_a: assert property (pdLeaveInternal
        |=> wakeCnt_q == WAKE_LOAD ##1 wakeCnt_q == WAKE_LOAD - WAKE_W'(1))
        else $error("wake counter not loaded on power-down exit");

    wake_invalid_a: assert property (wakeCnt_q != '0 |-> !sample.valid)
        else $error("result flagged valid during wake wait");

    swpd_keep_a: assert property (pdExit && !hwPd && !regReset
        |=> $stable(seqSel_q) && $stable(seqPwr_q))
        else $error("software power-down lost register contents");

    reg_reset_a: assert property (execNow && cmdNow == adc_seq_pkg::CMD_REGRESET
        |=> seqSel_q == adc_seq_pkg::SEQ_SEL_RST && mode_q == adc_seq_pkg::MODE_IDLE)
        else $error("register reset command not obeyed");

    scan_restart_a: assert property (autoRestartFrame
        |=> sample.channel == (lowest[4] ? lowest[3:0] : 4'h0) && sampleStrobe)
        else $error("auto scan did not restart at lowest channel");

    manual_hold_a: assert property (csFall && mode_q == adc_seq_pkg::MODE_MANUAL
        |=> sample.channel == $past(manChan_q) && sampleStrobe)
        else $error("manual mode sampled wrong channel");

    hold_word_a: assert property (execNow && !hwPd && cmdNow == adc_seq_pkg::CMD_HOLD
        |=> $stable(mode_q))
        else $error("all-zero command changed the mode");

    // only the first frame after the short command is judged; a later frame may be valid
    short_frame_a: assert property (execNow && isConv && !frameFull && !hwPd
        ##1 ((!csRise) throughout (##[0:299] csFall)) |=> !sample.valid)
        else $error("short command frame gave a valid first result");
endmodule

`default_nettype wire

// File: src/adc_seq_pkg.sv
// shared constants and types for the converter mode and channel sequencer
`default_nettype none
package adc_seq_pkg;
    // command words
    localparam logic [15:0] CMD_HOLD = 16'h0000;
    localparam logic [15:0] CMD_PWRDN = 16'h8300;
    localparam logic [15:0] CMD_REGRESET = 16'h8500;
    localparam logic [15:0] CMD_AUTO = 16'ha000;
    localparam logic [15:0] CMD_AUXILIARY_INPUT_SELECT = 16'he000;
    localparam logic [2:0] CMD_MAN_PREFIX = 3'h6;
    localparam int CMD_PREFIX_LSB = 13;
    localparam int CMD_CH_LSB = 10;
    localparam logic [9:0] CMD_MAN_TAIL = 10'h000;
    // program register command layout and register reset values
    localparam int CMD_RW_BIT = 8;
    localparam int ADDR_LSB = 9;
    localparam logic [6:0] ADDR_SEQ_SEL = 7'h01;
    localparam logic [6:0] ADDR_SEQ_PWR = 7'h02;
    localparam logic [6:0] ADDR_RANGE_BASE = 7'h05;
    localparam logic [7:0] SEQ_SEL_RST = 8'hff;
    localparam logic [7:0] SEQ_PWR_RST = 8'h00;
    localparam logic [7:0] RANGE_RST = 8'h00;
    // frame lengths in serial clocks, and the auxiliary input channel number
    localparam logic [5:0] CMD_BITS = 6'h10;
    localparam logic [5:0] FULL_FRAME = 6'h20;
    localparam logic [3:0] AUX_CHANNEL = 4'h8;
    // wake-up wait with internal reference
    localparam int WAKE_MS = 15;
    localparam int CLK_HZ = 25000000;
    localparam int WAKE_CYCLES = WAKE_MS * (CLK_HZ / 1000);
    // synchroniser lanes: chip select, word toggle, full toggle, ref select, hw power-down
    localparam logic [4:0] SYNC_RST = 5'h11;

    typedef enum logic [2:0] {
        MODE_IDLE = 3'b000,
        MODE_PWRDN = 3'b001,
        MODE_AUTO = 3'b010,
        MODE_MANUAL = 3'b011,
        MODE_INVALID = 3'b100
    } seqMode_t;

    typedef struct packed {
        logic [3:0] channel;
        logic [7:0] range;
        logic valid;
    } sampleInfo_t;
endpackage
`default_nettype wire

// File: test/adc_host_model.sv
// host controller model driving the serial command link of the sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_host_model (
    input wire logic linkClk,
    input wire logic serialOut,
    output logic serialClk,
    output logic chipSelectN,
    output logic serialIn
);
    initial begin
        serialClk = 1'b0;
        chipSelectN = 1'b1;
        serialIn = 1'b1;
    end

    // serial clock only runs inside a frame; read data is taken after the 16th fall
    task automatic frame(input logic [15:0] word, input int nclk, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge linkClk);
        chipSelectN <= 1'b0;
        for (int i = 0; i < nclk; i++) begin
            @(posedge linkClk);
            if (i >= 16 && i < 24) begin
                rd = {rd[6:0], serialOut};
            end
            serialClk <= 1'b1;
            serialIn <= (i < 16) ? word[15 - i] : 1'b0;
            @(negedge linkClk);
            serialClk <= 1'b0;
        end
        @(posedge linkClk);
        chipSelectN <= 1'b1;
        // idle data is not held at the last bit, so nothing can lean on it
        serialIn <= ~serialIn;
        repeat (20) @(posedge linkClk);
    endtask
endmodule
`default_nettype wire

// File: test/adc_mode_channel_sequencer_bench.sv
// self-checking bench for the converter mode and channel sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_mode_channel_sequencer_bench;
    localparam int unsigned WAKE = 20;
    localparam logic [3:0] AUTO_EXP [6] = '{4'h0, 4'h2, 4'h5, 4'h0, 4'h2, 4'h0};
    logic sys_clk;
    logic linkClk;
    logic rst_n;
    logic serialClk;
    logic chipSelectN;
    logic serialIn;
    logic referenceSelect;
    logic hwPowerDownN;
    logic serialOut;
    logic serialOutEn;
    adc_seq_pkg::seqMode_t mode;
    adc_seq_pkg::sampleInfo_t sample;
    logic sampleStrobe;
    logic analogEnable;
    logic [7:0] channelPowerEn;
    adc_seq_pkg::sampleInfo_t seen[$];
    logic [7:0] rd;
    int n_mismatch;
    int compares;

    adc_mode_channel_sequencer #(.NUM_CH(8), .WAKE_CYCLES(WAKE)) adc_mode_channel_sequencer_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .serialClk(serialClk), .chipSelectN(chipSelectN),
        .serialIn(serialIn), .referenceSelect(referenceSelect), .hwPowerDownN(hwPowerDownN),
        .serialOut(serialOut), .serialOutEn(serialOutEn), .mode(mode), .sample(sample),
        .sampleStrobe(sampleStrobe), .analogEnable(analogEnable),
        .channelPowerEn(channelPowerEn)
    );

    adc_host_model adc_host_model_inst (
        .linkClk(linkClk), .serialOut(serialOut), .serialClk(serialClk),
        .chipSelectN(chipSelectN), .serialIn(serialIn)
    );

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // link clock phase is deliberately unrelated to the system clock
    initial begin
        linkClk = 1'b0;
        #3.7;
        forever #6 linkClk = ~linkClk;
    end

    always @(posedge sys_clk) begin
        if (sampleStrobe === 1'b1) begin
            seen.push_back(sample);
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out;
        if (n_mismatch == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic send(input logic [15:0] w);
        adc_host_model_inst.frame(w, 32, rd);
    endtask

    task automatic wrReg(input logic [6:0] a, input logic [7:0] d);
        adc_host_model_inst.frame({a, 1'b1, d}, 16, rd);
    endtask

    task automatic rdReg(input logic [6:0] a, input logic [7:0] exp);
        adc_host_model_inst.frame({a, 1'b0, 8'h00}, 32, rd);
        check({8'h00, rd}, {8'h00, exp});
    endtask

    task automatic expSeen(input int idx, input logic [3:0] ch, input logic [7:0] rng,
                           input logic v);
        check({3'h0, seen[idx]}, {3'h0, ch, rng, v});
    endtask

    task automatic checkMode(input adc_seq_pkg::seqMode_t m);
        check({13'h0000, mode}, {13'h0000, m});
    endtask

    initial begin
        repeat (50000) @(posedge sys_clk);
        n_mismatch++;
        close_out;
    end

    initial begin
        n_mismatch = 0;
        compares = 0;
        rst_n = 1'b0;
        referenceSelect = 1'b1;
        hwPowerDownN = 1'b1;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        checkMode(adc_seq_pkg::MODE_IDLE);
        check({15'h0000, serialOutEn}, 16'h0000);
        rdReg(7'h01, 8'hff);
        rdReg(7'h02, 8'h00);
        wrReg(7'h06, 8'ha5);
        seen.delete();
        // every manual code back to back, then the aux input held by two empty frames
        for (int k = 0; k < 11; k++) begin
            send(k < 8 ? 16'hc000 + 16'(k) * 16'h0400 : (k == 8 ? 16'he000 : 16'h0000));
            if (k == 0) begin
                checkMode(adc_seq_pkg::MODE_MANUAL);
            end
        end
        for (int k = 0; k < 10; k++) begin
            expSeen(k, k < 8 ? 4'(k) : 4'h8, k == 1 ? 8'ha5 : 8'h00, 1'b1);
        end
        wrReg(7'h01, 8'h25);
        wrReg(7'h02, 8'h80);
        send(16'ha000);
        checkMode(adc_seq_pkg::MODE_AUTO);
        check({8'h00, channelPowerEn}, 16'h007f);
        seen.delete();
        // scan wraps after channel 5, and a repeated start returns to channel 0
        for (int k = 0; k < 6; k++) begin
            send(k == 4 ? 16'ha000 : 16'h0000);
        end
        for (int k = 0; k < 6; k++) begin
            expSeen(k, AUTO_EXP[k], 8'h00, 1'b1);
        end
        send(16'h8300);
        checkMode(adc_seq_pkg::MODE_PWRDN);
        check({7'h00, analogEnable, channelPowerEn}, 16'h0000);
        seen.delete();
        send(16'h0000);
        check(16'(seen.size()), 16'h0000);
        checkMode(adc_seq_pkg::MODE_PWRDN);
        rdReg(7'h01, 8'h25);
        wrReg(7'h06, 8'h3c);
        rdReg(7'h06, 8'h3c);
        @(posedge sys_clk);
        referenceSelect <= 1'b0;
        send(16'hc400);
        checkMode(adc_seq_pkg::MODE_MANUAL);
        check({15'h0000, analogEnable}, 16'h0001);
        send(16'h0000);
        expSeen(0, 4'h1, 8'h3c, 1'b0);
        // hazard: results are only trusted once the whole wake wait has run out
        repeat (WAKE) @(posedge sys_clk);
        send(16'h0000);
        expSeen(1, 4'h1, 8'h3c, 1'b1);
        send(16'h8500);
        checkMode(adc_seq_pkg::MODE_IDLE);
        rdReg(7'h01, 8'hff);
        rdReg(7'h06, 8'h00);
        wrReg(7'h01, 8'h00);
        send(16'ha000);
        seen.delete();
        send(16'h0000);
        expSeen(0, 4'h0, 8'h00, 1'b1);
        // a 16-clock manual command: its first result must be flagged, the next one not
        adc_host_model_inst.frame(16'hd400, 16, rd);
        send(16'h0000);
        expSeen(1, 4'h0, 8'h00, 1'b1);
        expSeen(2, 4'h5, 8'h00, 1'b0);
        adc_host_model_inst.frame(16'hc000, 8, rd);
        checkMode(adc_seq_pkg::MODE_INVALID);
        expSeen(3, 4'h5, 8'h00, 1'b1);
        wrReg(7'h01, 8'h33);
        @(posedge sys_clk);
        hwPowerDownN <= 1'b0;
        repeat (8) @(posedge sys_clk);
        checkMode(adc_seq_pkg::MODE_PWRDN);
        hwPowerDownN <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rdReg(7'h01, 8'hff);
        close_out;
    end
endmodule
`default_nettype wire
